// ### hdl/bzw_bus_timing.v
// bus zone timing top: register slave, region decode, cycle control
`timescale 1ns/1ps
`include "bzw_map.vh"
module bzw_bus_timing (
  input  wire        sys_clk,             // cpu clock, 40 MHz
  input  wire        rst_n,               // async reset, active low
  input  wire [7:0]  s_axi_awaddr,        // write address
  input  wire        s_axi_awvalid,       // write address valid
  output wire        s_axi_awready,       // write address ready
  input  wire [31:0] s_axi_wdata,         // write data
  input  wire [3:0]  s_axi_wstrb,         // write byte enables
  input  wire        s_axi_wvalid,        // write data valid
  output wire        s_axi_wready,        // write data ready
  output wire [1:0]  s_axi_bresp,         // write response
  output wire        s_axi_bvalid,        // write response valid
  input  wire        s_axi_bready,        // write response ready
  input  wire [7:0]  s_axi_araddr,        // read address
  input  wire        s_axi_arvalid,       // read address valid
  output wire        s_axi_arready,       // read address ready
  output wire [31:0] s_axi_rdata,         // read data
  output wire [1:0]  s_axi_rresp,         // read response
  output wire        s_axi_rvalid,        // read data valid
  input  wire        s_axi_rready,        // read data ready
  input  wire        cpu_req,             // cpu bus request, held to done
  input  wire [23:0] cpu_addr,            // cpu byte address
  input  wire        cpu_we,              // 1 write, 0 read
  input  wire        cpu_wide,            // 16-bit access
  output wire        cpu_ack,             // request taken
  output wire        cpu_done,            // cycle complete pulse
  output wire [23:0] bus_addr,            // address of current beat
  output wire [2:0]  bus_zone,            // region of current cycle
  output wire [2:0]  bus_phase,           // phase of current cycle
  output wire        zone2_select_strobe, // zone 2 select
  output wire        mem_rd_n,            // read strobe, active low
  output wire        mem_wr_n,            // write strobe, active low
  output wire        zone_width_select,   // 1 = 16-bit path
  output wire        internal_wait_cycle, // in a wait cycle
  output wire        burst_wait_cycle     // in a burst wait cycle
);
  // fast read limit checked against the fixed cpu clock
  wire fast_ok = (`BZW_CLK_HZ <= `BZW_FAST_MAX_HZ);

  // region decode, io zone wins over peripheral range
  function [2:0] zone_of;
    input [23:0] a;
    begin
      if (a <= 24'h03ffff || (a >= 24'h0e0000 && a <= 24'h0e1fff))
        zone_of = `BZW_ZN_FLASH;
      else if ((a >= 24'h0e8000 && a <= 24'h0e91ff) ||
               (a >= 24'h0ec000 && a <= 24'h0eebff))
        zone_of = `BZW_ZN_RAM;
      else if (a >= 24'hfffb00 && a <= 24'hfffbff)
        zone_of = `BZW_ZN_IO;
      else if ((a >= 24'h0ef000 && a <= 24'h0ef1ff) ||
               (a >= 24'hff0000 && a <= 24'hfffbff))
        zone_of = `BZW_ZN_PERIPH;
      else if (a >= `BZW_Z2_LO && a <= `BZW_Z2_HI)
        zone_of = `BZW_ZN_Z2;
      else
        zone_of = `BZW_ZN_NONE;
    end
  endfunction

  // byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    input [15:0] m;
    reg   [15:0] v;
    begin
      v = old;
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      merge16 = v & m;
    end
  endfunction

  // register file
  reg [15:0] bucfg_reg;
  reg [15:0] io_zone_reg;
  reg [15:0] z0cfg_reg;
  reg [15:0] z2cfg_reg;

  // axi4-lite write channel
  reg        aw_full_reg;
  reg [7:0]  aw_addr_reg;
  reg        w_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  wire       wr_go = aw_full_reg && w_full_reg && !bvalid_reg;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `BZW_RESP_OKAY;
      bucfg_reg   <= `BZW_RST_BUCFG;
      io_zone_reg <= `BZW_RST_ZCFG;
      z0cfg_reg   <= `BZW_RST_ZCFG;
      z2cfg_reg   <= `BZW_RST_ZCFG;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= `BZW_RESP_OKAY;
        case (aw_addr_reg)
          `BZW_OFS_BUCFG: bucfg_reg <= merge16(bucfg_reg, w_data_reg,
                                               w_strb_reg, `BZW_MSK_BUCFG);
          `BZW_OFS_IOZN: io_zone_reg <= merge16(io_zone_reg, w_data_reg,
                                                w_strb_reg, `BZW_MSK_IOZN);
          `BZW_OFS_Z0CFG: z0cfg_reg <= merge16(z0cfg_reg, w_data_reg,
                                               w_strb_reg, `BZW_MSK_ZCFG);
          `BZW_OFS_Z2CFG: z2cfg_reg <= merge16(z2cfg_reg, w_data_reg,
                                               w_strb_reg, `BZW_MSK_ZCFG);
          `BZW_OFS_STATUS: bresp_reg <= `BZW_RESP_OKAY;
          default: bresp_reg <= `BZW_RESP_SLVERR;
        endcase
      end
    end
  end

  // axi4-lite read channel
  reg        rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  rresp_reg;
  reg [15:0] status_val;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `BZW_RESP_OKAY;
    end else begin
      if (rvalid_reg && s_axi_rready)
        rvalid_reg <= 1'b0;
      if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= `BZW_RESP_OKAY;
        case (s_axi_araddr)
          `BZW_OFS_BUCFG:  rdata_reg <= {16'h0000, bucfg_reg};
          `BZW_OFS_IOZN:   rdata_reg <= {16'h0000, io_zone_reg & `BZW_MSK_IOZN};
          `BZW_OFS_Z0CFG:  rdata_reg <= {16'h0000, z0cfg_reg};
          `BZW_OFS_Z2CFG:  rdata_reg <= {16'h0000, z2cfg_reg};
          `BZW_OFS_STATUS: rdata_reg <= {16'h0000, status_val};
          default: begin
            rdata_reg <= 32'h00000000;
            rresp_reg <= `BZW_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // cycle state
  reg [2:0]  zone_reg;
  reg [2:0]  last_zone_reg;
  reg [23:0] addr_reg;
  reg        we_reg;
  reg        width_reg;
  reg        post_en_reg;
  reg        post_pend_reg;
  wire       seq_busy;
  wire       seq_done;
  wire       seq_beat;
  wire [2:0] seq_phase;

  // timing chosen for the request on offer
  wire [2:0] nz      = zone_of(cpu_addr);
  wire       chg     = (nz != last_zone_reg);
  wire       early   = bucfg_reg[`BZW_F_EARLY_WR];
  // zone 0 fast read dropped when the clock is above its limit
  wire       z0_fast = z0cfg_reg[`BZW_F_FAST_RD] && fast_ok;
  wire       z2_fast = z2cfg_reg[`BZW_F_FAST_RD];
  reg  [3:0] t_wait;
  reg  [1:0] t_hold;
  reg        t_pre_en;
  reg        t_pre_force;
  reg        t_post;
  reg        t_burst;
  reg        t_bwait;
  reg        t_two;
  reg        t_wide;
  wire [1:0] t_pre = {1'b0, t_pre_force | (t_pre_en & chg)} +
                     {1'b0, post_pend_reg & chg};

  always @* begin
    t_wait      = 4'h0;
    t_hold      = 2'h0;
    t_pre_en    = 1'b0;
    t_pre_force = 1'b0;
    t_post      = 1'b0;
    t_burst     = 1'b0;
    t_bwait     = 1'b0;
    t_two       = 1'b0;
    t_wide      = 1'b1;
    case (nz)
      `BZW_ZN_FLASH: begin
        t_wide   = z0cfg_reg[`BZW_F_WIDTH];
        t_pre_en = z0cfg_reg[`BZW_F_PRE_IDLE];
        t_post   = z0cfg_reg[`BZW_F_POST_IDLE];
        t_two    = cpu_wide && !z0cfg_reg[`BZW_F_WIDTH];
        if (z0_fast) begin
          t_wait = cpu_we ? 4'h1 : 4'h0;
        end else begin
          t_wait = {1'b0, z0cfg_reg[`BZW_F_WAIT]} + 4'h1 +
                   {3'h0, cpu_we & early};
          t_hold = z0cfg_reg[`BZW_F_HOLD];
        end
      end
      `BZW_ZN_RAM: t_wide = 1'b1;
      `BZW_ZN_PERIPH: begin
        t_wait      = 4'h1;
        t_pre_force = 1'b1;
      end
      `BZW_ZN_IO: begin
        t_wide = io_zone_reg[`BZW_F_WIDTH];
        t_post = io_zone_reg[`BZW_F_POST_IDLE];
        t_wait = {1'b0, io_zone_reg[`BZW_F_WAIT]} + 4'h1;
        t_hold = io_zone_reg[`BZW_F_HOLD];
        t_two  = cpu_wide && !io_zone_reg[`BZW_F_WIDTH];
      end
      `BZW_ZN_Z2: begin
        t_wide   = z2cfg_reg[`BZW_F_WIDTH];
        t_pre_en = z2cfg_reg[`BZW_F_PRE_IDLE];
        t_post   = z2cfg_reg[`BZW_F_POST_IDLE];
        if (z2_fast) begin
          t_wait = cpu_we ? 4'h1 : 4'h0;
        end else begin
          t_wait = {1'b0, z2cfg_reg[`BZW_F_WAIT]} + 4'h1;
          t_hold = z2cfg_reg[`BZW_F_HOLD];
        end
        if (cpu_wide && !z2cfg_reg[`BZW_F_WIDTH]) begin
          if (!cpu_we && !z2_fast && z2cfg_reg[`BZW_F_BURST_EN]) begin
            t_burst = 1'b1;
            t_bwait = z2cfg_reg[`BZW_F_BURST_WT];
          end else begin
            t_two = 1'b1;
          end
        end
      end
      default: t_wide = 1'b1;
    endcase
  end

  // no new request in the done cycle, so done never overlaps a start
  wire accept = cpu_req && !seq_busy && !seq_done;
  assign cpu_ack = accept;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_reg      <= `BZW_ZN_FLASH;
      last_zone_reg <= `BZW_ZN_FLASH;
      addr_reg      <= 24'h000000;
      we_reg        <= 1'b0;
      width_reg     <= 1'b1;
      post_en_reg   <= 1'b0;
      post_pend_reg <= 1'b0;
    end else begin
      if (accept) begin
        zone_reg      <= nz;
        last_zone_reg <= nz;
        addr_reg      <= cpu_addr;
        we_reg        <= cpu_we;
        width_reg     <= t_wide;
        post_en_reg   <= t_post;
        post_pend_reg <= 1'b0;
      end else if (seq_done) begin
        post_pend_reg <= post_en_reg;
      end
    end
  end

  bzw_cycle_seq u_seq (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .start    (accept),
    .pre_n    (t_pre),
    .wait_n   (t_wait),
    .hold_n   (t_hold),
    .burst    (t_burst),
    .bwait    (t_bwait),
    .two_beat (t_two),
    .phase    (seq_phase),
    .beat     (seq_beat),
    .busy     (seq_busy),
    .done     (seq_done)
  );

  // pin strobes decoded from sequencer state
  wire in_cyc = (seq_phase == `BZW_PH_T1) || (seq_phase == `BZW_PH_WAIT) ||
                (seq_phase == `BZW_PH_BWAIT) || (seq_phase == `BZW_PH_BT);
  wire in_sel = in_cyc || (seq_phase == `BZW_PH_HOLD);

  assign cpu_done            = seq_done;
  assign bus_addr            = {addr_reg[23:1], addr_reg[0] | seq_beat};
  assign bus_zone            = zone_reg;
  assign bus_phase           = seq_phase;
  assign zone2_select_strobe = in_sel && (zone_reg == `BZW_ZN_Z2);
  assign mem_rd_n            = !(in_cyc && !we_reg);
  assign mem_wr_n            = !(in_cyc && we_reg);
  assign zone_width_select   = width_reg;
  assign internal_wait_cycle = (seq_phase == `BZW_PH_WAIT);
  assign burst_wait_cycle    = (seq_phase == `BZW_PH_BWAIT);

  always @* begin
    status_val      = 16'h0000;
    status_val[0]   = seq_busy;
    status_val[3:1] = last_zone_reg;
    status_val[4]   = post_pend_reg;
    status_val[5]   = z0cfg_reg[`BZW_F_FAST_RD] && !fast_ok;
    status_val[6]   = width_reg;
  end
endmodule // bzw_bus_timing

// ### hdl/bzw_cycle_seq.v
// bus cycle sequencer: idle, T1, wait, burst and hold phases
`timescale 1ns/1ps
`include "bzw_map.vh"
module bzw_cycle_seq (
  input  wire       sys_clk,  // cpu clock
  input  wire       rst_n,    // async reset, active low
  input  wire       start,    // begin a cycle, only while idle
  input  wire [1:0] pre_n,    // idle cycles before T1
  input  wire [3:0] wait_n,   // wait cycles after T1
  input  wire [1:0] hold_n,   // hold cycles
  input  wire       burst,    // second beat as burst transfer
  input  wire       bwait,    // burst wait before burst beat
  input  wire       two_beat, // repeat full cycle for second byte
  output wire [2:0] phase,    // current phase
  output wire       beat,     // second byte beat
  output wire       busy,     // cycle under way
  output wire       done      // one-cycle pulse at completion
);
  localparam [2:0] PH_IDLE  = `BZW_PH_IDLE;
  localparam [2:0] PH_PRE   = `BZW_PH_PRE;
  localparam [2:0] PH_T1    = `BZW_PH_T1;
  localparam [2:0] PH_WAIT  = `BZW_PH_WAIT;
  localparam [2:0] PH_BWAIT = `BZW_PH_BWAIT;
  localparam [2:0] PH_BT    = `BZW_PH_BT;
  localparam [2:0] PH_HOLD  = `BZW_PH_HOLD;
  reg [2:0] phase_reg, phase_next;
  reg [3:0] cnt_reg, cnt_next;
  reg       beat_reg, beat_next;
  reg       done_reg;
  reg [3:0] wait_reg;
  reg [1:0] hold_reg;
  reg       burst_reg, bwait_reg, two_reg;
  wire       last_beat = !(two_reg && !beat_reg);
  wire [2:0] fin_ph    = last_beat ? PH_IDLE : PH_T1;
  wire [2:0] hold_ph   = (hold_reg != 2'h0) ? PH_HOLD : fin_ph;
  wire [2:0] aw_ph     = (burst_reg && !beat_reg) ?
                         (bwait_reg ? PH_BWAIT : PH_BT) : hold_ph;
  always @* begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg - 4'h1;
    beat_next  = beat_reg;
    case (phase_reg)
      PH_IDLE: begin
        beat_next = 1'b0;
        if (start) begin
          phase_next = (pre_n != 2'h0) ? PH_PRE : PH_T1;
          cnt_next   = {2'h0, pre_n} - 4'h1;
        end
      end
      PH_PRE:  if (cnt_reg == 4'h0) phase_next = PH_T1;
      PH_T1: begin
        phase_next = (wait_reg != 4'h0) ? PH_WAIT : aw_ph;
        cnt_next   = wait_reg - 4'h1;
      end
      PH_WAIT: if (cnt_reg == 4'h0) phase_next = aw_ph;
      PH_BWAIT: phase_next = PH_BT;
      PH_BT:   phase_next = hold_ph;
      PH_HOLD: if (cnt_reg == 4'h0) phase_next = fin_ph;
      default: phase_next = PH_IDLE;
    endcase
    if (phase_next == PH_HOLD && phase_reg != PH_HOLD)
      cnt_next = {2'h0, hold_reg} - 4'h1;
    if (phase_next == PH_BT || (phase_next == PH_T1 && phase_reg != PH_IDLE &&
        phase_reg != PH_PRE))
      beat_next = 1'b1;
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= 4'h0;
      beat_reg  <= 1'b0;
      done_reg  <= 1'b0;
      wait_reg  <= 4'h0;
      hold_reg  <= 2'h0;
      burst_reg <= 1'b0;
      bwait_reg <= 1'b0;
      two_reg   <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      beat_reg  <= beat_next;
      done_reg  <= (phase_reg != PH_IDLE) && (phase_next == PH_IDLE);
      if (phase_reg == PH_IDLE && start) begin
        wait_reg  <= wait_n;
        hold_reg  <= hold_n;
        burst_reg <= burst;
        bwait_reg <= bwait;
        two_reg   <= two_beat;
      end
    end
  end
  assign phase = phase_reg;
  assign beat  = beat_reg;
  assign busy  = (phase_reg != PH_IDLE);
  assign done  = done_reg;
endmodule // bzw_cycle_seq

// ### hdl/bzw_map.vh
// bus zone timing: register map, field layout, regions and codes
`ifndef BZW_MAP_VH
`define BZW_MAP_VH
`define BZW_OFS_BUCFG   8'h00
`define BZW_OFS_IOZN    8'h04
`define BZW_OFS_Z0CFG   8'h08
`define BZW_OFS_Z2CFG   8'h0c
`define BZW_OFS_STATUS  8'h10
`define BZW_RST_BUCFG   16'h0007
`define BZW_RST_ZCFG    16'h069f
`define BZW_MSK_BUCFG   16'h0007
`define BZW_MSK_IOZN    16'h029f
`define BZW_MSK_ZCFG    16'h0eff
`define BZW_F_WAIT      2:0
`define BZW_F_HOLD      4:3
`define BZW_F_BURST_EN  5
`define BZW_F_BURST_WT  6
`define BZW_F_WIDTH     7
`define BZW_F_POST_IDLE 9
`define BZW_F_PRE_IDLE  10
`define BZW_F_FAST_RD   11
`define BZW_F_EARLY_WR  0
`define BZW_CLK_HZ      40000000
`define BZW_FAST_MAX_HZ 24000000
`define BZW_ZN_FLASH    3'h0
`define BZW_ZN_RAM      3'h1
`define BZW_ZN_PERIPH   3'h2
`define BZW_ZN_IO       3'h3
`define BZW_ZN_Z2       3'h4
`define BZW_ZN_NONE     3'h5
`define BZW_PH_IDLE     3'h0
`define BZW_PH_PRE      3'h1
`define BZW_PH_T1       3'h2
`define BZW_PH_WAIT     3'h3
`define BZW_PH_BWAIT    3'h4
`define BZW_PH_BT       3'h5
`define BZW_PH_HOLD     3'h6
`define BZW_Z2_LO       24'h400000
`define BZW_Z2_HI       24'h7fffff
`define BZW_RESP_OKAY   2'h0
`define BZW_RESP_SLVERR 2'h2
`endif

// ### test/bzw_bus_timing_assertions.sv
// port checker for the bus zone timing block
`timescale 1ns/1ps
`include "bzw_map.vh"
module bzw_bus_timing_chk (
  input wire        sys_clk,             // cpu clock
  input wire        rst_n,               // reset, active low
  input wire        s_axi_bvalid,        // write resp valid
  input wire        s_axi_bready,        // write resp ready
  input wire [1:0]  s_axi_bresp,         // write resp
  input wire        s_axi_rvalid,        // read valid
  input wire        s_axi_rready,        // read ready
  input wire [31:0] s_axi_rdata,         // read data
  input wire        cpu_done,            // done pulse
  input wire [2:0]  bus_zone,            // region
  input wire [2:0]  bus_phase,           // phase
  input wire        zone2_select_strobe, // zone 2 select
  input wire        mem_rd_n,            // read strobe
  input wire        mem_wr_n,            // write strobe
  input wire [23:0] bus_addr,            // beat address
  input wire        internal_wait_cycle, // wait flag
  input wire        burst_wait_cycle     // burst wait flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_periph_t1;
    bus_phase == `BZW_PH_T1 && bus_zone == `BZW_ZN_PERIPH;
  endsequence
  sequence s_one_wait;
    bus_phase == `BZW_PH_WAIT ##1 bus_phase != `BZW_PH_WAIT;
  endsequence
  chk_strobe_zone: assert property (zone2_select_strobe |-> bus_zone == `BZW_ZN_Z2)
    else $error("zone 2 select outside zone 2");
  chk_wait_flag: assert property (bus_phase == `BZW_PH_WAIT |-> internal_wait_cycle)
    else $error("wait flag missing in wait phase");
  chk_burst_wait: assert property (burst_wait_cycle |-> bus_phase == `BZW_PH_BWAIT
    ##1 bus_phase == `BZW_PH_BT) else $error("burst wait not one cycle before burst beat");
  chk_ram_single: assert property (bus_phase == `BZW_PH_T1 && bus_zone == `BZW_ZN_RAM
    |=> bus_phase == `BZW_PH_IDLE) else $error("ram access longer than one cycle");
  chk_periph_wait: assert property (s_periph_t1 |=> s_one_wait)
    else $error("peripheral access not one wait cycle");
  chk_rd_phase: assert property (!mem_rd_n |-> bus_phase inside {`BZW_PH_T1,
    `BZW_PH_WAIT, `BZW_PH_BWAIT, `BZW_PH_BT}) else $error("read strobe outside access");
  chk_done_pulse: assert property ($rose(cpu_done) |=> !cpu_done)
    else $error("done longer than one cycle");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_wr_phase: assert property (!mem_wr_n |-> mem_rd_n && bus_phase inside {`BZW_PH_T1,
    `BZW_PH_WAIT}) else $error("write strobe outside access");
  chk_beat_addr: assert property (bus_phase == `BZW_PH_BT |-> bus_addr[0])
    else $error("burst beat not on odd byte");
endmodule // bzw_bus_timing_chk
bind bzw_bus_timing bzw_bus_timing_chk i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .cpu_done(cpu_done),
  .bus_zone(bus_zone), .bus_phase(bus_phase), .zone2_select_strobe(zone2_select_strobe),
  .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .bus_addr(bus_addr),
  .internal_wait_cycle(internal_wait_cycle), .burst_wait_cycle(burst_wait_cycle));

// ### test/bzw_bus_timing_tb_top.sv
// self-checking bench for bus zone timing
`timescale 1ns/1ps
`include "bzw_map.vh"
module bzw_bus_timing_tb_top;
  reg         sys_clk = 1'b0, rst_n = 1'b0;
  reg  [7:0]  awa = 8'h00, ara = 8'h00;
  reg  [31:0] wd = 32'h0;
  reg         awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  reg         cpu_req = 1'b0, cpu_we = 1'b0, cpu_wide = 1'b0;
  reg  [23:0] cpu_addr = 24'h0;
  wire        awr, wr, bv, arr, rv, ack, done, sel, rd_n, wr_n, wid, iw, bwt, wseen;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [23:0] baddr;
  wire [2:0]  bzone, bphase;
  wire [7:0]  scyc;
  integer     err_count = 0, check_count = 0, n, i;
  reg  [31:0] d;
  reg  [1:0]  r;
  always #12.5 sys_clk = ~sys_clk;
  bzw_bus_timing i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_wide(cpu_wide),
    .cpu_ack(ack), .cpu_done(done), .bus_addr(baddr), .bus_zone(bzone),
    .bus_phase(bphase), .zone2_select_strobe(sel), .mem_rd_n(rd_n), .mem_wr_n(wr_n),
    .zone_width_select(wid), .internal_wait_cycle(iw), .burst_wait_cycle(bwt));
  bzw_ext_mem i_mem (.sys_clk(sys_clk), .rst_n(rst_n), .zone2_select_strobe(sel),
    .mem_rd_n(rd_n), .zone_width_select(wid), .sel_cycles(scyc), .width_seen(wseen));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // response ready raised only after valid, so the stall path is used
  task axi_wr(input [7:0] a, input [15:0] v);
    integer k;
    begin
      @(posedge sys_clk);
      awa <= a;
      wd  <= {16'h0000, v};
      awv <= 1'b1;
      wv  <= 1'b1;
      for (k = 0; k < 60; k = k + 1) begin
        @(posedge sys_clk);
        if (awv && awr)
          awv <= 1'b0;
        if (wv && wr)
          wv <= 1'b0;
        if (bv && brd) begin
          r = bresp;
          brd <= 1'b0;
          k = 60;
        end else if (bv)
          brd <= 1'b1;
      end
    end
  endtask
  task axi_rd(input [7:0] a);
    integer k;
    begin
      @(posedge sys_clk);
      ara <= a;
      arv <= 1'b1;
      for (k = 0; k < 60; k = k + 1) begin
        @(posedge sys_clk);
        if (arv && arr)
          arv <= 1'b0;
        if (rv && rrd) begin
          d = rdata;
          r = rresp;
          rrd <= 1'b0;
          k = 60;
        end else if (rv)
          rrd <= 1'b1;
      end
    end
  endtask
  // n counts the taking edge and every edge up to the one that raises done
  task cyc(input [23:0] a, input we, input wide);
    begin
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_we   <= we;
      cpu_wide <= wide;
      cpu_req  <= 1'b1;
      i = 0;
      while (ack !== 1'b1 && i < 60) begin
        @(posedge sys_clk);
        i = i + 1;
      end
      n = 1;
      while (done !== 1'b1 && n < 200) begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
      @(posedge sys_clk);
      cpu_req <= 1'b0;
    end
  endtask
  // second of two like accesses, free of zone change idles
  task run2(input [23:0] a, input we, input wide, input integer exp);
    begin
      cyc(a, we, wide);
      cyc(a, we, wide);
      chk(n, exp);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #(20000 * 25);
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    axi_rd(`BZW_OFS_Z2CFG);
    chk(d, 32'h069f);
    axi_rd(`BZW_OFS_BUCFG);
    chk(d, 32'h0007);
    axi_wr(`BZW_OFS_Z2CFG, 16'hffff);
    axi_rd(`BZW_OFS_Z2CFG);
    chk(d, 32'h0eff);
    axi_wr(8'h20, 16'h1234);
    chk(r, `BZW_RESP_SLVERR);
    axi_rd(8'h20);
    chk(r, `BZW_RESP_SLVERR);
    chk(d, 32'h0);
    for (integer w = 0; w < 8; w = w + 1) begin
      axi_wr(`BZW_OFS_Z2CFG, 16'h0080 | w[2:0]);
      run2(`BZW_Z2_LO, 0, 0, w + 3);
    end
    for (integer h = 0; h < 4; h = h + 1) begin
      axi_wr(`BZW_OFS_Z2CFG, 16'h0080 | {h[1:0], 3'b000});
      run2(`BZW_Z2_LO, 0, 0, h + 3);
      chk(scyc, h + 2);
    end
    axi_wr(`BZW_OFS_Z2CFG, 16'h089f);
    run2(`BZW_Z2_LO, 0, 0, 2);
    for (integer b = 0; b < 2; b = b + 1) begin
      axi_wr(`BZW_OFS_Z2CFG, 16'h0020 | {b[0], 6'h00});
      run2(`BZW_Z2_LO, 0, 1, 4 + b);
      chk(wseen, 1'b0);
    end
    axi_wr(`BZW_OFS_Z2CFG, 16'h0000);
    run2(`BZW_Z2_LO, 0, 1, 5);
    axi_wr(`BZW_OFS_Z2CFG, 16'h00a0);
    run2(`BZW_Z2_LO, 0, 1, 3);
    chk(wseen, 1'b1);
    axi_wr(`BZW_OFS_Z2CFG, 16'h0480);
    cyc(24'h0e8000, 0, 0);
    cyc(`BZW_Z2_LO, 0, 0);
    chk(n, 4);
    cyc(`BZW_Z2_LO, 0, 0);
    chk(n, 3);
    axi_wr(`BZW_OFS_Z2CFG, 16'h0280);
    cyc(`BZW_Z2_LO, 0, 0);
    cyc(24'h0e8000, 0, 0);
    chk(n, 3);
    cyc(24'h0ec000, 1, 1);
    chk(n, 2);
    run2(24'h000100, 0, 1, 13);
    run2(24'h0e0000, 0, 1, 13);
    run2(24'h000100, 1, 1, 14);
    axi_wr(`BZW_OFS_BUCFG, 16'h0006);
    run2(24'h000100, 1, 1, 13);
    run2(24'h0ef000, 0, 1, 4);
    run2(24'hff0000, 1, 1, 4);
    run2(24'hfffb00, 0, 1, 13);
    axi_wr(`BZW_OFS_Z0CFG, 16'h0880);
    axi_rd(`BZW_OFS_STATUS);
    chk(d[5], 1'b1);
    run2(24'h000100, 0, 1, 3);
    run2(24'h000100, 1, 1, 3);
    test_done;
  end
endmodule // bzw_bus_timing_tb_top

// ### test/bzw_ext_mem.sv
// zone 2 static memory model: counts select cycles, notes width
`timescale 1ns/1ps
module bzw_ext_mem (
  input  wire       sys_clk,             // cpu clock
  input  wire       rst_n,               // reset, active low
  input  wire       zone2_select_strobe, // zone 2 select
  input  wire       mem_rd_n,            // read strobe
  input  wire       zone_width_select,   // path width
  output reg  [7:0] sel_cycles,          // select cycles of last access
  output reg        width_seen           // width during last read
);
  reg sel_prev_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_reg <= 1'b0;
      sel_cycles   <= 8'h00;
      width_seen   <= 1'b1;
    end else begin
      sel_prev_reg <= zone2_select_strobe;
      if (zone2_select_strobe) begin
        sel_cycles <= sel_prev_reg ? sel_cycles + 8'h01 : 8'h01;
        if (!mem_rd_n)
          width_seen <= zone_width_select;
      end
    end
  end
endmodule // bzw_ext_mem
